// File: shared/dlp_pkg.sv
/*
 * Package for the die-link port pin control block: register offsets, reset values,
 * field widths and the carrier structs shared by the design.
 * Assumes an 8-bit classic Wishbone slave with byte addresses equal to the register offsets.
 */
package dlp_pkg;

	// Register byte addresses.
	localparam logic [9:0] OFS_PORT_C_DATA   = 10'h004;
	localparam logic [9:0] OFS_PORT_D_DATA   = 10'h005;
	localparam logic [9:0] OFS_PORT_C_DIR    = 10'h006;
	localparam logic [9:0] OFS_PORT_D_DIR    = 10'h007;
	localparam logic [9:0] OFS_RSVD_LOW      = 10'h008;
	localparam logic [9:0] OFS_RSVD_HIGH     = 10'h019;
	localparam logic [9:0] OFS_SPI_PIN_LEVEL = 10'h120;
	localparam logic [9:0] OFS_LINK_CONTROL  = 10'h01A;

	// Field widths and positions.
	localparam int PORT_C_PINS   = 2;
	localparam int PORT_D_PINS   = 8;
	localparam int PORT_A_PINS   = 6;
	localparam int NARROW_PINS   = 4;
	localparam int CTRL_IRQ_BIT  = 0;
	localparam int CTRL_CLK_BIT  = 1;
	localparam int CTRL_DATA_BIT = 2;
	localparam int CTRL_WIDE_BIT = 3;
	localparam int CTRL_STOP_BIT = 4;

	// Reset values.
	localparam logic [7:0] RST_BYTE = 8'h00;

	// Synchroniser depth in flip-flops.
	localparam int SYNC_STAGES = 3;

	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [9:0] adr;
		logic [7:0] dat;
		logic       sel;
	} dlp_wb_req_type;

	typedef struct packed {
		logic [7:0] c_data;
		logic [7:0] d_data;
		logic [7:0] c_dir;
		logic [7:0] d_dir;
		logic [4:0] ctrl;
		logic       ack;
		logic [7:0] rdat;
	} dlp_state_type;

endpackage

// File: hdl/dlp_port_ctrl.sv
/*
 * Port pin control for the two-pin port C, the eight-pin port D and the input
 * readback of the six-pin port A, reached over an 8-bit classic Wishbone slave.
 * Assumes pad cells resolve the three-signal pins and apply pull-downs on request.
 */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps

module dlp_port_ctrl
(
	// Clock and reset.
	input  wire logic                    MCLK_I,
	input  wire logic                    RST_B_I,
	// Wishbone slave.
	input  wire logic                    WB_CYC_I,
	input  wire logic                    WB_STB_I,
	input  wire logic                    WB_WE_I,
	input  wire logic [9:0]              WB_ADR_I,
	input  wire logic [7:0]              WB_DAT_I,
	input  wire logic                    WB_SEL_I,
	output logic      [7:0]              WB_DAT_O,
	output logic                         WB_ACK_O,
	// Port C pins.
	input  wire logic [1:0]              PORTC_PIN_I,
	output logic      [1:0]              PORTC_PIN_O,
	output logic      [1:0]              PORTC_PIN_OE_O,
	output logic      [1:0]              PORTC_PULLDN_O,
	// Port D pins.
	input  wire logic [7:0]              PORTD_PIN_I,
	output logic      [7:0]              PORTD_PIN_O,
	output logic      [7:0]              PORTD_PIN_OE_O,
	output logic      [7:0]              PORTD_PULLDN_O,
	// Port A input levels.
	input  wire logic [5:0]              PORTA_PIN_I,
	// Die-link function side.
	input  wire logic                    DIE_LINK_CLK_OUT_I,
	input  wire logic [7:0]              DIE_LINK_DATA_OUT_I,
	input  wire logic [7:0]              DIE_LINK_DATA_OE_I,
	output logic      [7:0]              DIE_LINK_DATA_IN_O,
	output logic                         DIE_LINK_IRQ_IN_O
);

	logic [1:0]                      rst_sync_reg;
	logic                            rst_n;
	dlp_pkg::dlp_state_type          st_reg;
	dlp_pkg::dlp_state_type          st_next;
	logic [15:0]                     pin_raw;
	logic [15:0]                     sync1_reg;
	logic [15:0]                     sync2_reg;
	logic [15:0]                     sync3_reg;
	logic [15:0]                     pin_level;
	logic [1:0]                      c_level;
	logic [7:0]                      d_level;
	logic [5:0]                      a_level;
	logic                            irq_en;
	logic                            clk_en;
	logic                            data_en;
	logic                            stop_mode;
	logic [7:0]                      d_claim;
	logic                            req;
	logic [7:0]                      c_read;
	logic [7:0]                      d_read;

	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// Pin synchronisers carry no reset so the sampled levels are never forced.
	assign pin_raw = {PORTA_PIN_I, PORTD_PIN_I, PORTC_PIN_I};
	always_ff @(posedge MCLK_I)
	begin
		sync1_reg <= pin_raw;
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;
	end

	// A level is accepted once the second and third stages agree.
	logic [15:0] level_reg;
	always_ff @(posedge MCLK_I)
	begin
		level_reg <= ((sync2_reg ~^ sync3_reg) & sync3_reg)
			| (~(sync2_reg ~^ sync3_reg) & level_reg);
	end
	assign pin_level = level_reg;
	assign c_level   = pin_level[1:0];
	assign d_level   = pin_level[9:2];
	assign a_level   = pin_level[15:10];

	assign irq_en    = st_reg.ctrl[dlp_pkg::CTRL_IRQ_BIT];
	assign clk_en    = st_reg.ctrl[dlp_pkg::CTRL_CLK_BIT];
	assign data_en   = st_reg.ctrl[dlp_pkg::CTRL_DATA_BIT];
	assign stop_mode = st_reg.ctrl[dlp_pkg::CTRL_STOP_BIT];

	// Port D pins owned by the die-link data path.
	always_comb
	begin
		d_claim = 8'h00;
		if (data_en)
			d_claim = st_reg.ctrl[dlp_pkg::CTRL_WIDE_BIT] ? 8'hFF : 8'h0F;
	end

	// Data readback mixes stored bits and pin levels by direction.
	assign c_read = {6'h00, (st_reg.c_dir[1:0] & st_reg.c_data[1:0])
		| (~st_reg.c_dir[1:0] & c_level)};
	assign d_read = (st_reg.d_dir & st_reg.d_data) | (~st_reg.d_dir & d_level);

	assign req = WB_CYC_I && WB_STB_I && !st_reg.ack;

	always_comb
	begin
		st_next      = st_reg;
		st_next.ack  = req;
		st_next.rdat = 8'h00;
		if (req && WB_WE_I && WB_SEL_I)
		begin
			unique case (WB_ADR_I)
				dlp_pkg::OFS_PORT_C_DATA: st_next.c_data = {6'h00, WB_DAT_I[1:0]};
				dlp_pkg::OFS_PORT_D_DATA: st_next.d_data = WB_DAT_I;
				dlp_pkg::OFS_PORT_C_DIR:  st_next.c_dir  = {6'h00, WB_DAT_I[1:0]};
				dlp_pkg::OFS_PORT_D_DIR:  st_next.d_dir  = WB_DAT_I;
				dlp_pkg::OFS_LINK_CONTROL: st_next.ctrl  = WB_DAT_I[4:0];
				default: ;
			endcase
		end
		if (req && !WB_WE_I)
		begin
			unique case (WB_ADR_I)
				dlp_pkg::OFS_PORT_C_DATA:   st_next.rdat = c_read;
				dlp_pkg::OFS_PORT_D_DATA:   st_next.rdat = d_read;
				dlp_pkg::OFS_PORT_C_DIR:    st_next.rdat = st_reg.c_dir;
				dlp_pkg::OFS_PORT_D_DIR:    st_next.rdat = st_reg.d_dir;
				dlp_pkg::OFS_SPI_PIN_LEVEL: st_next.rdat = {2'h0, a_level};
				dlp_pkg::OFS_LINK_CONTROL:  st_next.rdat = {3'h0, st_reg.ctrl};
				default:                    st_next.rdat = 8'h00;
			endcase
		end
	end

	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg.c_data <= dlp_pkg::RST_BYTE;
			st_reg.d_data <= dlp_pkg::RST_BYTE;
			st_reg.c_dir  <= dlp_pkg::RST_BYTE;
			st_reg.d_dir  <= dlp_pkg::RST_BYTE;
			st_reg.ctrl   <= 5'h00;
			st_reg.ack    <= 1'b0;
			st_reg.rdat   <= dlp_pkg::RST_BYTE;
		end
		else
			st_reg <= st_next;
	end

	assign WB_ACK_O = st_reg.ack;
	assign WB_DAT_O = st_reg.rdat;

	// Port C pin 1: interrupt input or GPIO.
	assign PORTC_PIN_OE_O[1] = irq_en ? 1'b0 : st_reg.c_dir[1];
	assign PORTC_PIN_O[1]    = irq_en ? 1'b0 : st_reg.c_data[1];
	assign PORTC_PULLDN_O[1] = irq_en;
	// In stop mode the clock may halt, so the raw pin bypasses the synchroniser.
	assign DIE_LINK_IRQ_IN_O = irq_en & (stop_mode ? PORTC_PIN_I[1] : c_level[1]);

	// Port C pin 0: clock output or GPIO.
	assign PORTC_PIN_OE_O[0] = clk_en ? 1'b1 : st_reg.c_dir[0];
	assign PORTC_PIN_O[0]    = clk_en ? DIE_LINK_CLK_OUT_I : st_reg.c_data[0];
	assign PORTC_PULLDN_O[0] = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < dlp_pkg::PORT_D_PINS; gi++)
		begin : g_portd
			assign PORTD_PIN_OE_O[gi] = d_claim[gi] ? DIE_LINK_DATA_OE_I[gi]
				: st_reg.d_dir[gi];
			assign PORTD_PIN_O[gi]    = d_claim[gi] ? DIE_LINK_DATA_OUT_I[gi]
				: st_reg.d_data[gi];
			assign PORTD_PULLDN_O[gi] = d_claim[gi] & ~DIE_LINK_DATA_OE_I[gi];
			assign DIE_LINK_DATA_IN_O[gi] = d_claim[gi] & d_level[gi];
		end
	endgenerate

	// Assertions.
	property p_dir_d_reset;
		@(posedge MCLK_I) $rose(rst_n) |-> (st_reg.d_dir == 8'h00);
	endproperty
	a_dir_d_reset: assert property (p_dir_d_reset) else $error("port D direction not cleared");

	property p_c_dir_upper;
		@(posedge MCLK_I) disable iff (!rst_n) st_reg.c_dir[7:2] == 6'h00;
	endproperty
	a_c_dir_upper: assert property (p_c_dir_upper) else $error("port C direction upper set");

	property p_rsvd_read;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && !WB_WE_I && WB_ADR_I >= dlp_pkg::OFS_RSVD_LOW
			&& WB_ADR_I <= dlp_pkg::OFS_RSVD_HIGH) |=> (WB_ACK_O && WB_DAT_O == 8'h00);
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read not zero");

	property p_rsvd_write;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && WB_WE_I && WB_ADR_I >= dlp_pkg::OFS_RSVD_LOW
			&& WB_ADR_I <= dlp_pkg::OFS_RSVD_HIGH) |=> $stable({st_reg.c_data, st_reg.d_data,
			st_reg.c_dir, st_reg.d_dir, st_reg.ctrl});
	endproperty
	a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write changed state");

	property p_d_write;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && WB_WE_I && WB_SEL_I && WB_ADR_I == dlp_pkg::OFS_PORT_D_DIR)
			|=> (st_reg.d_dir == $past(WB_DAT_I) && WB_ACK_O);
	endproperty
	a_d_write: assert property (p_d_write) else $error("port D direction write lost");

	property p_d_read;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && !WB_WE_I && WB_ADR_I == dlp_pkg::OFS_PORT_D_DATA)
			|=> (WB_DAT_O == $past(d_read));
	endproperty
	a_d_read: assert property (p_d_read) else $error("port D read wrong");

	property p_narrow_free;
		@(posedge MCLK_I) disable iff (!rst_n)
		(data_en && !st_reg.ctrl[dlp_pkg::CTRL_WIDE_BIT])
			|-> (PORTD_PIN_OE_O[7:4] == st_reg.d_dir[7:4]);
	endproperty
	a_narrow_free: assert property (p_narrow_free) else $error("upper nibble not GPIO");

	property p_gpio_drive;
		@(posedge MCLK_I) disable iff (!rst_n)
		(!data_en) |-> (PORTD_PIN_OE_O == st_reg.d_dir && PORTD_PIN_O == st_reg.d_data);
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("GPIO drive mismatch");

	property p_irq_pin_input;
		@(posedge MCLK_I) disable iff (!rst_n)
		irq_en |-> (!PORTC_PIN_OE_O[1] && PORTC_PULLDN_O[1]);
	endproperty
	a_irq_pin_input: assert property (p_irq_pin_input) else $error("irq pin not input");

	// Bus handshake: one acknowledge per taken request, one cycle long.
	property p_ack_answer;
		@(posedge MCLK_I) disable iff (!rst_n)
		req |=> WB_ACK_O;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

	property p_ack_pulse;
		@(posedge MCLK_I) disable iff (!rst_n)
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held too long");

	property p_rdat_idle;
		@(posedge MCLK_I) disable iff (!rst_n)
		!WB_ACK_O |-> (WB_DAT_O == 8'h00);
	endproperty
	a_rdat_idle: assert property (p_rdat_idle) else $error("read data outside answer");

	property p_d_data_write;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && WB_WE_I && WB_SEL_I && WB_ADR_I == dlp_pkg::OFS_PORT_D_DATA)
			|=> (st_reg.d_data == $past(WB_DAT_I));
	endproperty
	a_d_data_write: assert property (p_d_data_write) else $error("port D data write lost");

	property p_c_write;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && WB_WE_I && WB_SEL_I && WB_ADR_I == dlp_pkg::OFS_PORT_C_DIR)
			|=> (st_reg.c_dir == ($past(WB_DAT_I) & 8'h03));
	endproperty
	a_c_write: assert property (p_c_write) else $error("port C direction write wrong");

	property p_sel_ignored;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && WB_WE_I && !WB_SEL_I) |=> $stable({st_reg.c_data, st_reg.d_data,
			st_reg.c_dir, st_reg.d_dir, st_reg.ctrl});
	endproperty
	a_sel_ignored: assert property (p_sel_ignored) else $error("disabled lane written");

	// Port A input levels: read-only and always the sampled pins.
	property p_spi_write;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && WB_WE_I && WB_ADR_I == dlp_pkg::OFS_SPI_PIN_LEVEL) |=> $stable({st_reg.c_data,
			st_reg.d_data, st_reg.c_dir, st_reg.d_dir, st_reg.ctrl});
	endproperty
	a_spi_write: assert property (p_spi_write) else $error("input register write had effect");

	property p_spi_read;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && !WB_WE_I && WB_ADR_I == dlp_pkg::OFS_SPI_PIN_LEVEL)
			|=> (WB_DAT_O == {2'h0, $past(a_level)});
	endproperty
	a_spi_read: assert property (p_spi_read) else $error("input register read wrong");

	property p_level_agree;
		@(posedge MCLK_I) disable iff (!rst_n)
		(sync2_reg == sync3_reg) |=> (level_reg == $past(sync3_reg));
	endproperty
	a_level_agree: assert property (p_level_agree) else $error("agreed level not taken");

	property p_c_read;
		@(posedge MCLK_I) disable iff (!rst_n)
		(req && !WB_WE_I && WB_ADR_I == dlp_pkg::OFS_PORT_C_DATA)
			|=> (WB_DAT_O == $past(c_read));
	endproperty
	a_c_read: assert property (p_c_read) else $error("port C read wrong");

	// Alternate functions on port C.
	property p_clk_pin;
		@(posedge MCLK_I) disable iff (!rst_n)
		clk_en |-> (PORTC_PIN_OE_O[0] && PORTC_PIN_O[0] == DIE_LINK_CLK_OUT_I);
	endproperty
	a_clk_pin: assert property (p_clk_pin) else $error("clock pin not driven");

	property p_c1_gpio;
		@(posedge MCLK_I) disable iff (!rst_n)
		!irq_en |-> (PORTC_PIN_OE_O[1] == st_reg.c_dir[1] && PORTC_PIN_O[1] == st_reg.c_data[1]);
	endproperty
	a_c1_gpio: assert property (p_c1_gpio) else $error("port C pin 1 not GPIO");

	property p_irq_gated;
		@(posedge MCLK_I) disable iff (!rst_n)
		!irq_en |-> !DIE_LINK_IRQ_IN_O;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("interrupt input while disabled");

	property p_irq_stop;
		@(posedge MCLK_I) disable iff (!rst_n)
		(irq_en && stop_mode) |-> (DIE_LINK_IRQ_IN_O == PORTC_PIN_I[1]);
	endproperty
	a_irq_stop: assert property (p_irq_stop) else $error("stop bypass not taken");

	// Data path claim on port D.
	property p_wide_claim;
		@(posedge MCLK_I) disable iff (!rst_n)
		(data_en && st_reg.ctrl[dlp_pkg::CTRL_WIDE_BIT]) |-> (PORTD_PIN_OE_O == DIE_LINK_DATA_OE_I
			&& PORTD_PIN_O == DIE_LINK_DATA_OUT_I);
	endproperty
	a_wide_claim: assert property (p_wide_claim) else $error("wide claim missing");

	property p_narrow_link;
		@(posedge MCLK_I) disable iff (!rst_n)
		(data_en && !st_reg.ctrl[dlp_pkg::CTRL_WIDE_BIT])
			|-> (PORTD_PIN_OE_O[3:0] == DIE_LINK_DATA_OE_I[3:0]);
	endproperty
	a_narrow_link: assert property (p_narrow_link) else $error("narrow claim missing");

	property p_link_in_mask;
		@(posedge MCLK_I) disable iff (!rst_n)
		!data_en |-> (DIE_LINK_DATA_IN_O == 8'h00);
	endproperty
	a_link_in_mask: assert property (p_link_in_mask) else $error("link input leaks");

	property p_d_pulldown;
		@(posedge MCLK_I) disable iff (!rst_n)
		!data_en |-> (PORTD_PULLDN_O == 8'h00);
	endproperty
	a_d_pulldown: assert property (p_d_pulldown) else $error("GPIO pin pulled down");

endmodule // dlp_port_ctrl

// File: verification/dlp_pin_model.sv
/*
 * Behavioural model of the pads and the far-side drivers on port C and port D.
 * Assumes the bench supplies the external drive values and their enables.
 */
`timescale 1ns/1ps
module dlp_pin_model
(
	// Device side.
	input  wire logic [7:0] d_o_i,
	input  wire logic [7:0] d_oe_i,
	input  wire logic [7:0] d_pd_i,
	input  wire logic [1:0] c_o_i,
	input  wire logic [1:0] c_oe_i,
	input  wire logic [1:0] c_pd_i,
	// Far side.
	input  wire logic [7:0] d_ext_i,
	input  wire logic [7:0] d_ext_oe_i,
	input  wire logic [1:0] c_ext_i,
	input  wire logic [1:0] c_ext_oe_i,
	// Resolved levels.
	output logic      [7:0] d_lvl_o,
	output logic      [1:0] c_lvl_o
);
	// A released pin without pull-down shows the inverse of the last external value.
	assign d_lvl_o = (d_oe_i & d_o_i) | (~d_oe_i & d_ext_oe_i & d_ext_i)
		| (~d_oe_i & ~d_ext_oe_i & ~d_pd_i & ~d_ext_i);
	assign c_lvl_o = (c_oe_i & c_o_i) | (~c_oe_i & c_ext_oe_i & c_ext_i)
		| (~c_oe_i & ~c_ext_oe_i & ~c_pd_i & ~c_ext_i);
endmodule // dlp_pin_model

// File: verification/testbench.sv
/*
 * Self-checking bench for the die-link port pin control block.
 * Assumes the package offsets and the one-cycle Wishbone answer of the design.
 */
`timescale 1ns/1ps
module testbench;
	logic        MCLK_I = 0, RST_B_I = 0, cyc = 0, stb = 0, we = 0, ack, irq, clk_o = 0, sel = 1;
	logic [9:0]  adr = 0;
	logic [7:0]  wdat = 0, rdat, q, r, d_lout = 0, d_loe = 0, d_ext = 0, d_xoe = 8'hFF;
	logic [7:0]  d_o, d_oe, d_pd, d_in, d_lvl;
	logic [1:0]  c_o, c_oe, c_pd, c_ext = 0, c_lvl;
	logic [5:0]  a_pin = 0;
	logic [16:0] seed = 17'h1_7809;
	int          error_cnt = 0, compares = 0;

	dlp_port_ctrl dlp_port_ctrl_inst (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .PORTC_PIN_I(c_lvl), .PORTC_PIN_O(c_o),
		.PORTC_PIN_OE_O(c_oe), .PORTC_PULLDN_O(c_pd), .PORTD_PIN_I(d_lvl), .PORTD_PIN_O(d_o),
		.PORTD_PIN_OE_O(d_oe), .PORTD_PULLDN_O(d_pd), .PORTA_PIN_I(a_pin),
		.DIE_LINK_CLK_OUT_I(clk_o), .DIE_LINK_DATA_OUT_I(d_lout), .DIE_LINK_DATA_OE_I(d_loe),
		.DIE_LINK_DATA_IN_O(d_in), .DIE_LINK_IRQ_IN_O(irq));
	dlp_pin_model dlp_pin_model_inst (.d_o_i(d_o), .d_oe_i(d_oe), .d_pd_i(d_pd), .c_o_i(c_o),
		.c_oe_i(c_oe), .c_pd_i(c_pd), .d_ext_i(d_ext), .d_ext_oe_i(d_xoe), .c_ext_i(c_ext),
		.c_ext_oe_i(2'h3), .d_lvl_o(d_lvl), .c_lvl_o(c_lvl));

	always #2.5 MCLK_I = ~MCLK_I;

	function automatic logic [7:0] rnd8();
		seed = {seed[15:0], seed[16] ^ seed[13]};
		return seed[7:0];
	endfunction

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge MCLK_I);
		while (ack !== 1'b1)
			@(posedge MCLK_I);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge MCLK_I);
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e, input string n);
		wb(1'b0, a, 8'h00);
		chk(n, q, e);
	endtask

	task automatic give_verdict();
		$display("error_cnt %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		#100000;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		repeat (20) @(posedge MCLK_I);
		RST_B_I <= 1'b1;
		repeat (3) @(posedge MCLK_I);
		for (int i = 4; i < 8; i++)
			rd(10'(i), 8'h00, "reset value");
		r = rnd8();
		wb(1'b1, dlp_pkg::OFS_PORT_D_DATA, r);
		wb(1'b1, dlp_pkg::OFS_PORT_D_DIR, 8'hFF);
		@(negedge MCLK_I);
		chk("d drive", d_o, r);
		chk("d enable", d_oe, 8'hFF);
		@(posedge MCLK_I);
		rd(dlp_pkg::OFS_PORT_D_DATA, r, "d data out");
		d_ext <= rnd8();
		r = rnd8();
		c_ext <= r[1:0];
		r = rnd8();
		a_pin <= r[5:0];
		wb(1'b1, dlp_pkg::OFS_PORT_D_DIR, 8'h00);
		chk("d released", d_oe, 8'h00);
		repeat (6) @(posedge MCLK_I);
		rd(dlp_pkg::OFS_PORT_D_DATA, d_ext, "d data in");
		rd(dlp_pkg::OFS_PORT_C_DATA, {6'h00, c_ext}, "c data in");
		rd(dlp_pkg::OFS_SPI_PIN_LEVEL, {2'h0, a_pin}, "a level");
		wb(1'b1, dlp_pkg::OFS_SPI_PIN_LEVEL, 8'hFF);
		rd(dlp_pkg::OFS_SPI_PIN_LEVEL, {2'h0, a_pin}, "a read only");
		wb(1'b1, dlp_pkg::OFS_PORT_C_DIR, 8'hFF);
		rd(dlp_pkg::OFS_PORT_C_DIR, 8'h03, "c dir");
		wb(1'b1, dlp_pkg::OFS_PORT_C_DATA, 8'hFF);
		rd(dlp_pkg::OFS_PORT_C_DATA, 8'h03, "c data out");
		wb(1'b1, dlp_pkg::OFS_RSVD_LOW, 8'hFF);
		wb(1'b1, dlp_pkg::OFS_RSVD_HIGH, 8'hFF);
		rd(dlp_pkg::OFS_RSVD_LOW, 8'h00, "reserved low");
		rd(dlp_pkg::OFS_RSVD_HIGH, 8'h00, "reserved high");
		rd(dlp_pkg::OFS_PORT_D_DIR, 8'h00, "reserved side effect");
		sel <= 1'b0;
		wb(1'b1, dlp_pkg::OFS_PORT_D_DIR, 8'hFF);
		sel <= 1'b1;
		rd(dlp_pkg::OFS_PORT_D_DIR, 8'h00, "lane off ignored");
		r = rnd8();
		d_loe <= rnd8();
		d_lout <= rnd8();
		wb(1'b1, dlp_pkg::OFS_PORT_D_DIR, r);
		wb(1'b1, dlp_pkg::OFS_LINK_CONTROL, 8'h04);
		@(negedge MCLK_I);
		chk("narrow enable", d_oe, {r[7:4], d_loe[3:0]});
		chk("narrow out", {4'h0, d_o[3:0]}, {4'h0, d_lout[3:0]});
		@(posedge MCLK_I);
		rd(dlp_pkg::OFS_PORT_D_DIR, r, "dir kept");
		wb(1'b1, dlp_pkg::OFS_LINK_CONTROL, 8'h0C);
		@(negedge MCLK_I);
		chk("wide enable", d_oe, d_loe);
		chk("wide pulldown", d_pd, ~d_loe);
		repeat (6) @(posedge MCLK_I);
		chk("link in", d_in, (d_loe & d_lout) | (~d_loe & d_ext));
		clk_o <= 1'b1;
		wb(1'b1, dlp_pkg::OFS_LINK_CONTROL, 8'h03);
		@(negedge MCLK_I);
		chk("c link pins", {4'h0, c_oe, c_pd}, 8'h06);
		chk("clock out", {7'h00, c_o[0]}, 8'h01);
		repeat (6) @(posedge MCLK_I);
		chk("irq in", {7'h00, irq}, {7'h00, c_ext[1]});
		wb(1'b1, dlp_pkg::OFS_LINK_CONTROL, 8'h13);
		c_ext <= ~c_ext;
		@(negedge MCLK_I);
		chk("irq bypass", {7'h00, irq}, {7'h00, c_ext[1]});
		give_verdict();
	end
endmodule // testbench
